// ==== include/acddpc_pkg.sv ====
package acddpc_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the serial control port
    // ------------------------------------------------------------------
    localparam logic [14:0] OFS_DEVICE_CHANNEL_INDEX = 15'h0008;
    localparam logic [14:0] OFS_REFERENCE_SOURCE_SELECT = 15'h0024;
    localparam logic [14:0] OFS_TEMP_DIODE_CONTROL = 15'h0028;
    localparam logic [14:0] OFS_POWER_MODE_CONTROL_A = 15'h003f;
    localparam logic [14:0] OFS_POWER_MODE_AND_PIN_FUNCTION = 15'h0040;
    localparam logic [14:0] OFS_CLOCK_DIVIDER_RATIO = 15'h010b;
    localparam logic [14:0] OFS_HALF_CYCLE_DELAY_CONTROL = 15'h010c;
    localparam logic [14:0] OFS_DIVIDER_SYNC_CONTROL = 15'h010d;
    localparam logic [14:0] OFS_FINE_DELAY_ENABLE = 15'h0117;
    localparam logic [14:0] OFS_FINE_DELAY_VALUE = 15'h0118;
    localparam logic [14:0] OFS_STANDBY_OUTPUT_CONTROL = 15'h0571;

    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int BIT_SYNC_ENABLE = 7;
    localparam int BIT_STANDBY_K_CHARS = 7;
    localparam int BIT_FINE_ENABLE = 0;
    localparam int BIT_TEMP_DIODE_ENABLE = 0;
    localparam int BIT_REF_EXTERNAL = 0;
    localparam int BIT_SOFT_POWER_DOWN = 0;
    localparam int BIT_HALF_DELAY = 0;
    localparam int LSB_PIN_FUNCTION = 6;
    localparam logic [1:0] PIN_FUNC_POWER_DOWN = 2'h0;
    localparam logic [1:0] PIN_FUNC_STANDBY = 2'h1;
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_BY_8 = 2'h3;
    localparam logic [2:0] DETECT_SEL_TEMP_DIODE = 3'h6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DEVICE_CHANNEL_INDEX = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Serial frame layout and timing
    // ------------------------------------------------------------------
    localparam int INSTR_BITS = 16;
    localparam int DATA_BITS = 8;
    localparam int CLOCK_PERIOD_NS = 20;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_INSTR = 2'b01,
        SER_DATA = 2'b10,
        SER_DONE = 2'b11
    } acddpc_ser_t;

endpackage

// ==== verilog/acddpc_top.sv ====
// What this block does
// - Input clock divides by one, two, four or eight per the divider ratio register.
// - A valid SYSREF event resets the divider to a programmable phase.
// - SYSREF alignment works only while bit 7 of divider sync control is set.
// - Half-cycle phase delay is enabled separately per channel.
// - Writing the half-cycle delay register leaves the serial link undisturbed.
// - Fine delay enable is bit 0; the fine delay value is an eight-bit field.
// - Fine delay spans about -151.7 ps to +150 ps per channel, 1.7 ps steps.
// - Fine delay takes effect right after the enabling write, no extra command.
// - Setting the fine delay enable bit resets the converter datapath.
// - Changing the fine delay value does not disturb the serial link.
// - Power pin selects full power-down or standby; power-down after reset.
// - Power pin is active high.
// - Full power-down stops the serial output link.
// - Full power-down can also be requested through the power mode registers.
// - Standby keeps the link running and sends zero samples.
// - With standby output bit 7 set, standby sends /K/ characters instead.
// - Temperature diode control bit 0 enables or disables the diode.
// - Three-bit pin function field chooses the fast-detect pin source.
// - Reference select chooses internal or external 1.0 V reference.
// - Divide-by-two output has a 50% duty cycle regardless of input.
`timescale 1ns/1ps

module acddpc_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Serial control port
    input wire logic CSB_N,
    input wire logic SCLK,
    input wire logic SDIO_IN,
    output logic SDIO_OUT,
    output logic SDIO_OE_N,
    // Alignment and power pins
    input wire logic SYSREF,
    input wire logic POWER_STANDBY_PIN,
    // Sample clock path controls
    output logic [1:0] DIV_CLK,
    output logic [1:0] SAMPLE_TICK,
    output logic [1:0] HALF_CYCLE_DELAY,
    output logic [1:0] FINE_DELAY_EN,
    output logic [15:0] FINE_DELAY_CODE,
    output logic DATAPATH_RESET,
    // Power and link state
    output logic FULL_POWER_DOWN,
    output logic STANDBY,
    output logic LINK_ENABLE,
    output logic SEND_ZERO_SAMPLES,
    output logic SEND_K_CHARS,
    // Analog housekeeping
    output logic TEMP_DIODE_EN,
    output logic [2:0] CHANNEL_A_FAST_DETECT_SEL,
    output logic TEMP_TO_CHANNEL_A_FAST_DETECT_PIN,
    output logic REF_EXTERNAL
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        acddpc_pkg::acddpc_ser_t ser;
        logic sclk_q;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic rd;
        logic [14:0] addr;
        logic [7:0] out_shift;
        logic sdio_out;
        logic sdio_oe_n;
        logic [7:0] dev_index;
        logic [7:0] ref_sel;
        logic [7:0] temp_ctl;
        logic [7:0] pwr_a;
        logic [7:0] pwr_pin_fn;
        logic [7:0] div_ratio;
        logic [1:0][7:0] half_delay;
        logic [7:0] sync_ctl;
        logic [1:0][7:0] fine_en;
        logic [1:0][7:0] fine_val;
        logic [7:0] standby_ctl;
        logic sysref_q;
        logic [2:0] div_cnt;
        logic [1:0] div_clk;
        logic [1:0] tick;
        logic dp_rst;
        logic power_down;
        logic standby;
    } acddpc_state_t;

    acddpc_state_t cur;
    acddpc_state_t next_cur;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Mask of live divider counter bits for a ratio code.
    function automatic logic [2:0] ratio_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            acddpc_pkg::DIV_BY_2: m = 3'h1;
            acddpc_pkg::DIV_BY_4: m = 3'h3;
            acddpc_pkg::DIV_BY_8: m = 3'h7;
            default: m = 3'h0;
        endcase
        return m;
    endfunction

    // Read mux; per-channel registers read back channel A when it is selected.
    function automatic logic [7:0] read_reg(input acddpc_state_t s, input logic [14:0] a);
        logic [7:0] d;
        logic ch;
        d = 8'h00;
        ch = ~s.dev_index[0];
        if (a == acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX) begin
            d = s.dev_index;
        end else if (a == acddpc_pkg::OFS_REFERENCE_SOURCE_SELECT) begin
            d = s.ref_sel;
        end else if (a == acddpc_pkg::OFS_TEMP_DIODE_CONTROL) begin
            d = s.temp_ctl;
        end else if (a == acddpc_pkg::OFS_POWER_MODE_CONTROL_A) begin
            d = s.pwr_a;
        end else if (a == acddpc_pkg::OFS_POWER_MODE_AND_PIN_FUNCTION) begin
            d = s.pwr_pin_fn;
        end else if (a == acddpc_pkg::OFS_CLOCK_DIVIDER_RATIO) begin
            d = s.div_ratio;
        end else if (a == acddpc_pkg::OFS_HALF_CYCLE_DELAY_CONTROL) begin
            d = s.half_delay[ch];
        end else if (a == acddpc_pkg::OFS_DIVIDER_SYNC_CONTROL) begin
            d = s.sync_ctl;
        end else if (a == acddpc_pkg::OFS_FINE_DELAY_ENABLE) begin
            d = s.fine_en[ch];
        end else if (a == acddpc_pkg::OFS_FINE_DELAY_VALUE) begin
            d = s.fine_val[ch];
        end else if (a == acddpc_pkg::OFS_STANDBY_OUTPUT_CONTROL) begin
            d = s.standby_ctl;
        end else begin
            d = 8'h00;
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // All behaviour is computed here from the registered state and the pins.
    always_comb begin
        logic sclk_rise;
        logic sclk_fall;
        logic wr_now;
        logic [7:0] wdata;
        logic [2:0] mask;
        logic sysref_rise;
        logic pin_power_down;
        logic pin_standby;
        next_cur = cur;
        sclk_rise = SCLK & ~cur.sclk_q;
        sclk_fall = ~SCLK & cur.sclk_q;
        wr_now = 1'b0;
        wdata = {cur.shift[6:0], SDIO_IN};
        mask = ratio_mask(cur.div_ratio[1:0]);
        sysref_rise = SYSREF & ~cur.sysref_q;
        pin_power_down = 1'b0;
        pin_standby = 1'b0;
        next_cur.sclk_q = SCLK;
        next_cur.sysref_q = SYSREF;
        next_cur.dp_rst = 1'b0;

        // Serial control port: 16-bit instruction then one data byte, MSB first.
        // Bits are taken on SCLK rising, read data changes on SCLK falling.
        if (CSB_N) begin
            next_cur.ser = acddpc_pkg::SER_IDLE;
            next_cur.sdio_oe_n = 1'b1;
            next_cur.bit_cnt = 5'h00;
        end else begin
            case (cur.ser)
                acddpc_pkg::SER_IDLE: begin
                    next_cur.ser = acddpc_pkg::SER_INSTR;
                    next_cur.bit_cnt = 5'h00;
                    if (sclk_rise) begin
                        next_cur.shift = {cur.shift[14:0], SDIO_IN};
                        next_cur.bit_cnt = 5'h01;
                    end
                end
                acddpc_pkg::SER_INSTR: begin
                    if (sclk_rise) begin
                        next_cur.shift = {cur.shift[14:0], SDIO_IN};
                        next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        if (cur.bit_cnt == 5'(acddpc_pkg::INSTR_BITS - 1)) begin
                            next_cur.rd = cur.shift[14];
                            next_cur.addr = {cur.shift[13:0], SDIO_IN};
                            next_cur.out_shift = read_reg(cur, {cur.shift[13:0], SDIO_IN});
                            next_cur.bit_cnt = 5'h00;
                            next_cur.ser = acddpc_pkg::SER_DATA;
                        end
                    end
                end
                acddpc_pkg::SER_DATA: begin
                    if (sclk_fall && cur.rd) begin
                        next_cur.sdio_out = cur.out_shift[7];
                        next_cur.sdio_oe_n = 1'b0;
                        next_cur.out_shift = {cur.out_shift[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        next_cur.shift = {cur.shift[14:0], SDIO_IN};
                        next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        if (cur.bit_cnt == 5'(acddpc_pkg::DATA_BITS - 1)) begin
                            wr_now = ~cur.rd;
                            next_cur.ser = acddpc_pkg::SER_DONE;
                        end
                    end
                end
                acddpc_pkg::SER_DONE: begin
                    // Further bits in the frame are ignored; release the line after the byte.
                    if (sclk_fall) begin
                        next_cur.sdio_oe_n = 1'b1;
                    end
                end
                default: begin
                    next_cur.ser = acddpc_pkg::SER_IDLE;
                end
            endcase
        end

        // Register writes. Per-channel registers go to every channel selected in
        // the index register. The diode control is local to channel A only, so a
        // write with channel A deselected is dropped.
        if (wr_now) begin
            if (cur.addr == acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX) begin
                next_cur.dev_index = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_REFERENCE_SOURCE_SELECT) begin
                next_cur.ref_sel = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_TEMP_DIODE_CONTROL) begin
                if (cur.dev_index[0]) begin
                    next_cur.temp_ctl = wdata;
                end
            end else if (cur.addr == acddpc_pkg::OFS_POWER_MODE_CONTROL_A) begin
                next_cur.pwr_a = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_POWER_MODE_AND_PIN_FUNCTION) begin
                next_cur.pwr_pin_fn = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_CLOCK_DIVIDER_RATIO) begin
                next_cur.div_ratio = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_HALF_CYCLE_DELAY_CONTROL) begin
                // No datapath or link reset is raised here, so the link keeps lock.
                for (int c = 0; c < 2; c++) begin
                    if (cur.dev_index[c]) begin
                        next_cur.half_delay[c] = wdata;
                    end
                end
            end else if (cur.addr == acddpc_pkg::OFS_DIVIDER_SYNC_CONTROL) begin
                next_cur.sync_ctl = wdata;
            end else if (cur.addr == acddpc_pkg::OFS_FINE_DELAY_ENABLE) begin
                for (int c = 0; c < 2; c++) begin
                    if (cur.dev_index[c]) begin
                        next_cur.fine_en[c] = wdata;
                        // Only a 0-to-1 change of the enable resets the datapath.
                        if (wdata[acddpc_pkg::BIT_FINE_ENABLE]
                            && !cur.fine_en[c][acddpc_pkg::BIT_FINE_ENABLE]) begin
                            next_cur.dp_rst = 1'b1;
                        end
                    end
                end
            end else if (cur.addr == acddpc_pkg::OFS_FINE_DELAY_VALUE) begin
                // The value is retimed straight to the delay line, with no reset.
                for (int c = 0; c < 2; c++) begin
                    if (cur.dev_index[c]) begin
                        next_cur.fine_val[c] = wdata;
                    end
                end
            end else if (cur.addr == acddpc_pkg::OFS_STANDBY_OUTPUT_CONTROL) begin
                next_cur.standby_ctl = wdata;
            end
        end

        // Divider counter. A SYSREF edge reloads the programmed phase only while
        // alignment is enabled; otherwise the counter free-runs untouched.
        if (sysref_rise && cur.sync_ctl[acddpc_pkg::BIT_SYNC_ENABLE]) begin
            next_cur.div_cnt = cur.sync_ctl[2:0] & mask;
        end else if ((cur.div_cnt & mask) == mask) begin
            next_cur.div_cnt = 3'h0;
        end else begin
            next_cur.div_cnt = (cur.div_cnt + 3'h1) & mask;
        end

        // Divided clock per channel. Taking a counter bit gives equal high and
        // low times, so divide-by-two is 50% however the input duty looks.
        for (int c = 0; c < 2; c++) begin
            next_cur.tick[c] = (next_cur.div_cnt == 3'h0) && !cur.power_down;
            case (cur.div_ratio[1:0])
                acddpc_pkg::DIV_BY_2: next_cur.div_clk[c] = next_cur.div_cnt[0];
                acddpc_pkg::DIV_BY_4: next_cur.div_clk[c] = next_cur.div_cnt[1];
                acddpc_pkg::DIV_BY_8: next_cur.div_clk[c] = next_cur.div_cnt[2];
                default: next_cur.div_clk[c] = 1'b1;
            endcase
            if (cur.power_down) begin
                next_cur.div_clk[c] = 1'b0;
            end
        end

        // Power modes. The pin is active high; its function resets to power-down.
        if (cur.pwr_pin_fn[7:6] == acddpc_pkg::PIN_FUNC_POWER_DOWN) begin
            pin_power_down = POWER_STANDBY_PIN;
        end else if (cur.pwr_pin_fn[7:6] == acddpc_pkg::PIN_FUNC_STANDBY) begin
            pin_standby = POWER_STANDBY_PIN;
        end
        next_cur.power_down = pin_power_down
            | cur.pwr_a[acddpc_pkg::BIT_SOFT_POWER_DOWN];
        next_cur.standby = pin_standby & ~next_cur.power_down;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Every register runs on every edge; reset loads constants only.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur <= '0;
            cur.ser <= acddpc_pkg::SER_IDLE;
            cur.sdio_oe_n <= 1'b1;
            cur.dev_index <= acddpc_pkg::RST_DEVICE_CHANNEL_INDEX;
            cur.pwr_pin_fn <= acddpc_pkg::RST_ZERO;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // All outputs are flop-driven fields of the state, some through simple gates or a compare.
    assign SDIO_OUT = cur.sdio_out;
    assign SDIO_OE_N = cur.sdio_oe_n;
    assign DIV_CLK = cur.div_clk;
    assign SAMPLE_TICK = cur.tick;
    assign HALF_CYCLE_DELAY = {cur.half_delay[1][acddpc_pkg::BIT_HALF_DELAY],
                               cur.half_delay[0][acddpc_pkg::BIT_HALF_DELAY]};
    assign FINE_DELAY_EN = {cur.fine_en[1][acddpc_pkg::BIT_FINE_ENABLE],
                            cur.fine_en[0][acddpc_pkg::BIT_FINE_ENABLE]};
    assign FINE_DELAY_CODE = {cur.fine_val[1], cur.fine_val[0]};
    assign DATAPATH_RESET = cur.dp_rst;
    assign FULL_POWER_DOWN = cur.power_down;
    assign STANDBY = cur.standby;
    // The link is only dropped by full power-down; standby keeps it framed.
    assign LINK_ENABLE = ~cur.power_down;
    assign SEND_ZERO_SAMPLES =
        cur.standby & ~cur.standby_ctl[acddpc_pkg::BIT_STANDBY_K_CHARS];
    assign SEND_K_CHARS =
        cur.standby & cur.standby_ctl[acddpc_pkg::BIT_STANDBY_K_CHARS];
    assign TEMP_DIODE_EN = cur.temp_ctl[acddpc_pkg::BIT_TEMP_DIODE_ENABLE];
    assign CHANNEL_A_FAST_DETECT_SEL = cur.pwr_pin_fn[2:0];
    assign TEMP_TO_CHANNEL_A_FAST_DETECT_PIN =
        (cur.pwr_pin_fn[2:0] == acddpc_pkg::DETECT_SEL_TEMP_DIODE);
    assign REF_EXTERNAL = cur.ref_sel[acddpc_pkg::BIT_REF_EXTERNAL];

endmodule

// ==== testbench/acddpc_chk.sv ====
`timescale 1ns/1ps
module acddpc_chk (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Watched pins
    input wire logic POWER_STANDBY_PIN,
    input wire logic [1:0] SAMPLE_TICK,
    input wire logic [1:0] FINE_DELAY_EN,
    input wire logic DATAPATH_RESET,
    input wire logic FULL_POWER_DOWN,
    input wire logic STANDBY,
    input wire logic LINK_ENABLE,
    input wire logic SEND_ZERO_SAMPLES,
    input wire logic SEND_K_CHARS,
    input wire logic [2:0] CHANNEL_A_FAST_DETECT_SEL,
    input wire logic TEMP_TO_CHANNEL_A_FAST_DETECT_PIN
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // A channel whose fine delay enable has just come on.
    sequence s_fine_rise;
        (FINE_DELAY_EN & ~$past(FINE_DELAY_EN)) != 2'h0;
    endsequence
    // Power-down held long enough for the tick register to follow.
    sequence s_pd_held;
        FULL_POWER_DOWN ##1 FULL_POWER_DOWN;
    endsequence
    a_link_stops_pd: assert property (LINK_ENABLE == !FULL_POWER_DOWN)
        else $error("link enable disagrees with power-down");
    a_pd_over_standby: assert property (FULL_POWER_DOWN |-> !STANDBY)
        else $error("standby shown during power-down");
    a_standby_pin_high: assert property (STANDBY |-> $past(POWER_STANDBY_PIN))
        else $error("standby without a high power pin");
    a_zero_in_standby: assert property (SEND_ZERO_SAMPLES |-> STANDBY && !SEND_K_CHARS)
        else $error("zero samples outside standby");
    a_k_in_standby: assert property (SEND_K_CHARS |-> STANDBY)
        else $error("K characters outside standby");
    a_dp_reset_pulse: assert property (DATAPATH_RESET |-> s_fine_rise ##1 !DATAPATH_RESET)
        else $error("datapath reset not a single pulse on enable");
    a_no_tick_pd: assert property (s_pd_held |-> SAMPLE_TICK == 2'h0)
        else $error("sample ticks during power-down");
    a_temp_route: assert property (TEMP_TO_CHANNEL_A_FAST_DETECT_PIN ==
        (CHANNEL_A_FAST_DETECT_SEL == acddpc_pkg::DETECT_SEL_TEMP_DIODE))
        else $error("diode routing disagrees with pin select");
endmodule

bind acddpc_top acddpc_chk i_acddpc_chk (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .POWER_STANDBY_PIN(POWER_STANDBY_PIN), .SAMPLE_TICK(SAMPLE_TICK),
    .FINE_DELAY_EN(FINE_DELAY_EN), .DATAPATH_RESET(DATAPATH_RESET),
    .FULL_POWER_DOWN(FULL_POWER_DOWN), .STANDBY(STANDBY), .LINK_ENABLE(LINK_ENABLE),
    .SEND_ZERO_SAMPLES(SEND_ZERO_SAMPLES), .SEND_K_CHARS(SEND_K_CHARS),
    .CHANNEL_A_FAST_DETECT_SEL(CHANNEL_A_FAST_DETECT_SEL),
    .TEMP_TO_CHANNEL_A_FAST_DETECT_PIN(TEMP_TO_CHANNEL_A_FAST_DETECT_PIN));

// ==== testbench/acddpc_host.sv ====
`timescale 1ns/1ps
module acddpc_host (
    // Clock
    input wire logic clock,
    // Serial control port
    output logic csb_n,
    output logic sclk,
    output logic sdio_in,
    input wire logic sdio_out
);
    // Idle levels: serial clock parked low, chip select off.
    initial begin
        csb_n = 1'b1;
        sclk = 1'b0;
        sdio_in = 1'b0;
    end
    // One 24-bit frame; three low and two high cycles a bit keep the sampler safe.
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [23:0] f;
        f = {rw, a, wd};
        rd = 8'h00;
        @(posedge clock) csb_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clock) sclk <= 1'b0;
            sdio_in <= f[i];
            repeat (2) @(posedge clock);
            @(posedge clock) sclk <= 1'b1;
            if (i < 8) rd[i] = sdio_out;
            @(posedge clock);
        end
        @(posedge clock) sclk <= 1'b0;
        repeat (2) @(posedge clock);
        @(posedge clock) csb_n <= 1'b1;
        sdio_in <= ~sdio_in;
    endtask
endmodule

// ==== testbench/acddpc_top_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module acddpc_top_test;
    logic CLOCK, ARST_N, SYSREF, POWER_STANDBY_PIN, CSB_N, SCLK, SDIO_IN, SDIO_OUT;
    logic SDIO_OE_N, DATAPATH_RESET, FULL_POWER_DOWN, STANDBY, LINK_ENABLE;
    logic SEND_ZERO_SAMPLES, SEND_K_CHARS, TEMP_DIODE_EN, TEMP_TO_DETECT, REF_EXTERNAL;
    logic [1:0] DIV_CLK, SAMPLE_TICK, HALF_CYCLE_DELAY, FINE_DELAY_EN;
    logic [15:0] FINE_DELAY_CODE;
    logic [2:0] DETECT_SEL;
    // Four-state sums, so an unknown tick or clock level shows up as a mismatch.
    logic [31:0] t, h;
    logic [7:0] r, v;
    logic [31:0] seed = 32'h59da;
    int bad_count = 0, cmp_count = 0, dp_count = 0, d0, d1, d4;
    acddpc_top i_acddpc_top (.CLOCK(CLOCK), .ARST_N(ARST_N), .CSB_N(CSB_N), .SCLK(SCLK),
        .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE_N(SDIO_OE_N), .SYSREF(SYSREF),
        .POWER_STANDBY_PIN(POWER_STANDBY_PIN), .DIV_CLK(DIV_CLK), .SAMPLE_TICK(SAMPLE_TICK),
        .HALF_CYCLE_DELAY(HALF_CYCLE_DELAY), .FINE_DELAY_EN(FINE_DELAY_EN),
        .FINE_DELAY_CODE(FINE_DELAY_CODE), .DATAPATH_RESET(DATAPATH_RESET),
        .FULL_POWER_DOWN(FULL_POWER_DOWN), .STANDBY(STANDBY), .LINK_ENABLE(LINK_ENABLE),
        .SEND_ZERO_SAMPLES(SEND_ZERO_SAMPLES), .SEND_K_CHARS(SEND_K_CHARS),
        .TEMP_DIODE_EN(TEMP_DIODE_EN), .CHANNEL_A_FAST_DETECT_SEL(DETECT_SEL),
        .TEMP_TO_CHANNEL_A_FAST_DETECT_PIN(TEMP_TO_DETECT), .REF_EXTERNAL(REF_EXTERNAL));
    acddpc_host i_acddpc_host (.clock(CLOCK), .csb_n(CSB_N), .sclk(SCLK),
        .sdio_in(SDIO_IN), .sdio_out(SDIO_OUT));
    // ----------
    // Helpers
    // ----------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Expected ticks and high cycles of the divided clock over n cycles.
    function automatic int ticks_in(input int code, input int n);
        return n >> code;
    endfunction
    function automatic int highs_in(input int code, input int n);
        return (code == 0) ? n : n / 2;
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] dv);
        logic [7:0] x;
        i_acddpc_host.xfer(1'b0, a, dv, x);
        @(negedge CLOCK);
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        i_acddpc_host.xfer(1'b1, a, 8'h00, q);
    endtask
    // Cycles from a SYSREF rise to the next channel A tick, pre cycles after a tick.
    task automatic meas(input int pre, output int dd);
        int k;
        k = 0;
        do begin @(negedge CLOCK); k++; end while (SAMPLE_TICK[0] !== 1'b1 && k < 20);
        repeat (pre) @(posedge CLOCK);
        @(posedge CLOCK) SYSREF <= 1'b1;
        dd = 0;
        do begin @(negedge CLOCK); dd++; end while (SAMPLE_TICK[0] !== 1'b1 && dd < 20);
        @(posedge CLOCK) SYSREF <= 1'b0;
        if (k >= 20 || dd >= 20) begin bad_count++; report_and_stop(); end
    endtask
    // Datapath reset pulses are counted at mid-cycle, where they are settled.
    always @(negedge CLOCK) if (DATAPATH_RESET === 1'b1) dp_count++;
    initial begin CLOCK = 1'b0; forever #10 CLOCK = ~CLOCK; end
    // ----------
    // Main sequence
    // ----------
    initial begin
        ARST_N = 1'b0;
        SYSREF = 1'b0;
        POWER_STANDBY_PIN = 1'b0;
        repeat (2) @(posedge CLOCK);
        ARST_N <= 1'b1;
        rd(15'h008, r);
        `CHK(r, acddpc_pkg::RST_DEVICE_CHANNEL_INDEX);
        for (int c = 0; c < 4; c++) begin
            wr(acddpc_pkg::OFS_CLOCK_DIVIDER_RATIO, 8'(c));
            t = 0;
            h = 0;
            repeat (16) begin @(negedge CLOCK); t += SAMPLE_TICK[0]; h += DIV_CLK[0]; end
            `CHK(t, ticks_in(c, 16));
            `CHK(h, highs_in(c, 16));
        end
        meas(2, d0);
        `CHK(d0, 6);
        wr(acddpc_pkg::OFS_DIVIDER_SYNC_CONTROL, 8'h80);
        meas(2, d0);
        meas(5, d1);
        `CHK(d1, d0);
        wr(acddpc_pkg::OFS_DIVIDER_SYNC_CONTROL, 8'h84);
        meas(3, d4);
        `CHK((d4 - d0 + 8) % 8, 4);
        @(posedge CLOCK) POWER_STANDBY_PIN <= 1'b1;
        repeat (3) @(negedge CLOCK);
        `CHK(FULL_POWER_DOWN, 1'b1);
        `CHK(LINK_ENABLE, 1'b0);
        @(posedge CLOCK) POWER_STANDBY_PIN <= 1'b0;
        wr(acddpc_pkg::OFS_POWER_MODE_AND_PIN_FUNCTION, 8'h46);
        `CHK(TEMP_TO_DETECT, 1'b1);
        @(posedge CLOCK) POWER_STANDBY_PIN <= 1'b1;
        repeat (3) @(negedge CLOCK);
        `CHK({FULL_POWER_DOWN, STANDBY, SEND_ZERO_SAMPLES, LINK_ENABLE}, 4'h7);
        wr(acddpc_pkg::OFS_STANDBY_OUTPUT_CONTROL, 8'h80);
        `CHK({SEND_ZERO_SAMPLES, SEND_K_CHARS}, 2'h1);
        @(posedge CLOCK) POWER_STANDBY_PIN <= 1'b0;
        wr(acddpc_pkg::OFS_POWER_MODE_CONTROL_A, 8'h01);
        `CHK({FULL_POWER_DOWN, STANDBY}, 2'h2);
        wr(acddpc_pkg::OFS_POWER_MODE_CONTROL_A, 8'h00);
        wr(acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX, 8'h02);
        wr(acddpc_pkg::OFS_TEMP_DIODE_CONTROL, 8'h01);
        `CHK(TEMP_DIODE_EN, 1'b0);
        wr(acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX, 8'h01);
        wr(acddpc_pkg::OFS_TEMP_DIODE_CONTROL, 8'h01);
        `CHK(TEMP_DIODE_EN, 1'b1);
        wr(acddpc_pkg::OFS_TEMP_DIODE_CONTROL, 8'h00);
        `CHK(TEMP_DIODE_EN, 1'b0);
        wr(acddpc_pkg::OFS_HALF_CYCLE_DELAY_CONTROL, 8'h01);
        `CHK({HALF_CYCLE_DELAY, LINK_ENABLE}, 3'h3);
        wr(acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX, 8'h03);
        repeat (4) begin
            seed = xs(seed);
            v = seed[7:0];
            wr(acddpc_pkg::OFS_FINE_DELAY_VALUE, v);
            rd(acddpc_pkg::OFS_FINE_DELAY_VALUE, r);
            `CHK(r, v);
            `CHK(FINE_DELAY_CODE, {v, v});
        end
        `CHK(dp_count, 0);
        wr(acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX, 8'h02);
        wr(acddpc_pkg::OFS_FINE_DELAY_VALUE, 8'hff);
        `CHK(FINE_DELAY_CODE, {8'hff, v});
        wr(acddpc_pkg::OFS_DEVICE_CHANNEL_INDEX, 8'h03);
        wr(acddpc_pkg::OFS_FINE_DELAY_ENABLE, 8'h01);
        `CHK(FINE_DELAY_EN, 2'h3);
        `CHK(dp_count, 1);
        wr(acddpc_pkg::OFS_REFERENCE_SOURCE_SELECT, 8'h01);
        `CHK(REF_EXTERNAL, 1'b1);
        rd(15'h123, r);
        `CHK({r, SDIO_OE_N}, 9'h001);
        report_and_stop();
    end
endmodule
